// ### dv/gpio_ports_tb.sv
// Self-checking testbench of the GPIO ports block.
module gpio_ports_tb
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, cyc, stb, we;
	logic [WB_ADR_W-1:0] adr;
	logic [WB_SEL_W-1:0] sel;
	logic [WB_DAT_W-1:0] wdat, wb_dat_o;
	logic wb_ack_o;
	logic [7:0] wide_ext, narrow_ext, wide_pin, narrow_pin, pullup_on_o, dir, dat, ext;
	logic [7:0] mix, keep;
	pin_drive_s wide_drv, narrow_drv;
	logic [31:0] expq[$];
	int err_total, checks, cycles;

	gpio_ports i_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wide_pin_i(wide_pin), .wide_pin_o(wide_drv),
		.narrow_pin_i(narrow_pin), .narrow_pin_o(narrow_drv), .pullup_on_o(pullup_on_o));
	pin_partner i_wide (.drv(wide_drv), .ext(wide_ext), .pin(wide_pin));
	pin_partner i_narrow (.drv(narrow_drv), .ext(narrow_ext), .pin(narrow_pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One classic cycle; a read notes its expected data for the watcher.
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
		input logic [7:0] exp);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		sel <= 4'hf;
		if (!w) expq.push_back({24'h000000, exp});
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && we === 1'b0) begin
			chk("rd_data", wb_dat_o, expq.size() > 0 ? expq.pop_front() : 'x);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		reset = 1'b1;
		wide_ext = 8'h5a;
		narrow_ext = 8'h5a;
		void'($urandom(32'h7445));
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("pullup_rst", pullup_on_o, PULLUP_ON_RST);
		chk("oe_rst", {wide_drv.oe, narrow_drv.oe}, 16'h0000);
		bus(1'b0, WIDE_DIR_IDX, 8'h00, WRITE_ONLY_READ);
		bus(1'b0, NARROW_DIR_IDX, 8'h00, WRITE_ONLY_READ);
		bus(1'b0, 16'h0100, 8'h00, UNMAPPED_READ[7:0]);
		bus(1'b1, WIDE_DIR_IDX, 8'hff, 8'h00);
		bus(1'b1, NARROW_DIR_IDX, 8'hff, 8'h00);
		bus(1'b0, WIDE_DATA_IDX, 8'h00, WIDE_DATA_RST);
		bus(1'b0, NARROW_DATA_IDX, 8'h00, NARROW_DATA_RST);
		for (int i = 0; i < 6; i++) begin
			dir = 8'($urandom);
			dat = 8'($urandom);
			ext = 8'($urandom);
			mix = (dat & dir) | (ext & ~dir);
			keep = dir | ~NARROW_IMPL_MASK;
			wide_ext <= ext;
			narrow_ext <= ext;
			bus(1'b1, WIDE_DIR_IDX, dir, 8'h00);
			bus(1'b1, WIDE_DATA_IDX, dat, 8'h00);
			bus(1'b1, NARROW_DIR_IDX, dir, 8'h00);
			bus(1'b1, NARROW_DATA_IDX, dat, 8'h00);
			bus(1'b1, PULLUP_DIR_IDX, dir, 8'h00);
			bus(1'b1, PULLUP_EN_IDX, dat, 8'h00);
			repeat (3) @(posedge clk);
			chk("wide_oe", wide_drv.oe, dir);
			chk("wide_dout", wide_drv.dout & dir, dat & dir);
			chk("narrow_oe", narrow_drv.oe, dir & NARROW_IMPL_MASK);
			chk("narrow_dout", narrow_drv.dout & keep, dat & dir & NARROW_IMPL_MASK);
			chk("pullup_on", pullup_on_o, ~dir & dat);
			bus(1'b0, WIDE_DATA_IDX, 8'h00, mix);
			bus(1'b0, NARROW_DATA_IDX, 8'h00, mix & NARROW_IMPL_MASK);
		end
		bus(1'b0, PULLUP_DIR_IDX, 8'h00, WRITE_ONLY_READ);
		bus(1'b0, PULLUP_EN_IDX, 8'h00, dat);
		bus(1'b1, POWER_MODE_IDX, 8'(MODE_SUBACTIVE), 8'h00);
		bus(1'b1, WIDE_DATA_IDX, ~dat, 8'h00);
		repeat (3) @(posedge clk);
		chk("subactive_drive", {wide_drv.oe, wide_drv.dout & dir}, {dir, ~dat & dir});
		bus(1'b1, POWER_MODE_IDX, 8'(MODE_SLEEP), 8'h00);
		bus(1'b1, WIDE_DATA_IDX, dat, 8'h00);
		repeat (3) @(posedge clk);
		chk("sleep_hold", {wide_drv.oe, wide_drv.dout & dir}, {dir, ~dat & dir});
		bus(1'b1, POWER_MODE_IDX, 8'(MODE_STANDBY), 8'h00);
		bus(1'b0, POWER_MODE_IDX, 8'h00, 8'(MODE_STANDBY));
		repeat (3) @(posedge clk);
		chk("standby_oe", {wide_drv.oe, narrow_drv.oe}, 16'h0000);
		chk("standby_pullup", pullup_on_o, ~dir & dat);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("rerst", {wide_drv.oe, narrow_drv.oe, pullup_on_o}, 24'h000000);
		bus(1'b1, WIDE_DIR_IDX, 8'hff, 8'h00);
		bus(1'b1, NARROW_DIR_IDX, 8'hff, 8'h00);
		bus(1'b0, WIDE_DATA_IDX, 8'h00, WIDE_DATA_RST);
		bus(1'b0, NARROW_DATA_IDX, 8'h00, NARROW_DATA_RST);
		bus(1'b0, POWER_MODE_IDX, 8'h00, 8'(MODE_ACTIVE));
		repeat (2) @(posedge clk);
		chk("queue_left", expq.size(), 0);
		final_report();
	end
endmodule // gpio_ports_tb

// ### dv/pin_partner.sv
// External device model that resolves each pin from the port drive and its own level.
module pin_partner
	import gpio_pkg::*;
(
	input  wire pin_drive_s        drv,  // Drive value and enable from the port.
	input  wire logic [PORT_W-1:0] ext,  // Level the external device applies.
	output logic      [PORT_W-1:0] pin   // Resolved pin level.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Where the port drives, the device only listens; elsewhere it drives its own level.
	assign pin = (drv.oe & drv.dout) | (~drv.oe & ext);
endmodule // pin_partner

// ### src/gpio_pkg.sv
// Package with register indices, reset values, modes and pin carriers of the GPIO block.
package gpio_pkg;

	localparam int          PORT_W            = 8;
	localparam int          WB_DAT_W          = 32;
	localparam int          WB_ADR_W          = 18;
	localparam int          WB_SEL_W          = 4;
	localparam int          IDX_W             = 16;

	// Register indices; the byte address of each is four times its index.
	localparam logic [15:0] WIDE_DATA_IDX     = 16'hffd9;
	localparam logic [15:0] NARROW_DATA_IDX   = 16'hffda;
	localparam logic [15:0] WIDE_DIR_IDX      = 16'hffe9;
	localparam logic [15:0] NARROW_DIR_IDX    = 16'hffea;
	localparam logic [15:0] PULLUP_DIR_IDX    = 16'hfff0;
	localparam logic [15:0] PULLUP_EN_IDX     = 16'hfff1;
	localparam logic [15:0] POWER_MODE_IDX    = 16'hfff2;

	localparam logic [7:0]  WIDE_DATA_RST     = 8'h00;
	localparam logic [7:0]  WIDE_DIR_RST      = 8'h00;
	localparam logic [7:0]  NARROW_DATA_RST   = 8'h00;
	localparam logic [7:0]  NARROW_DIR_RST    = 8'h00;
	localparam logic [7:0]  PULLUP_DIR_RST    = 8'h00;
	localparam logic [7:0]  PULLUP_EN_RST     = 8'h00;
	localparam logic [7:0]  PULLUP_ON_RST     = 8'h00;
	localparam logic [7:0]  WRITE_ONLY_READ   = 8'hff;
	localparam logic [7:0]  NARROW_IMPL_MASK  = 8'hf8;
	localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;
	localparam int          MODE_POS          = 0;
	localparam int          MODE_W            = 2;

	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_SUBACTIVE,
		MODE_SLEEP,
		MODE_STANDBY
	} power_mode_e;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe;
	} pin_drive_s;

endpackage // gpio_pkg

// ### src/gpio_ports.sv
// Two parallel GPIO ports and pull-up gating of a third port behind a Wishbone slave.
//
// Function
// - Pull-up on only for input with enable (pull-ups hold in sleep, whatever direction and enable say)
// - Output pin keeps pull-up off always (pull-ups hold in sleep, so a pin made output in sleep keeps its pull-up)
// - All pull-ups off after reset
// - Wide data register cleared by reset
// - Wide output bits read back data register
// - Wide input bits read pin level
// - Wide direction one is output, zero input
// - Wide direction resets zero, reads all ones
// - Pins high-z reset/standby, hold in sleep
// - Pull-up stays on, high level in standby
// - Narrow low three bits read zero
// - Narrow output bits read data register
// - Narrow input bits read pin level
// - Narrow direction bits seven to three
// - Narrow direction reads all ones
// - Reset clears narrow data and direction
//
// Our own choice: the Wishbone interface to the registers.
module gpio_ports
	import gpio_pkg::*;
(
	input  wire logic                clk,           // System clock, 100 MHz.
	input  wire logic                reset,         // Synchronous reset, active high.
	input  wire logic                wb_cyc_i,      // Wishbone cycle.
	input  wire logic                wb_stb_i,      // Wishbone strobe.
	input  wire logic                wb_we_i,       // Wishbone write enable.
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,      // Wishbone byte address.
	input  wire logic [WB_SEL_W-1:0] wb_sel_i,      // Wishbone byte selects.
	input  wire logic [WB_DAT_W-1:0] wb_dat_i,      // Wishbone write data.
	output logic      [WB_DAT_W-1:0] wb_dat_o,      // Wishbone read data.
	output logic                     wb_ack_o,      // Wishbone acknowledge.
	input  wire logic [PORT_W-1:0]   wide_pin_i,    // Wide port pin levels.
	output pin_drive_s               wide_pin_o,    // Wide port drive value and enable.
	input  wire logic [PORT_W-1:0]   narrow_pin_i,  // Narrow port pin levels.
	output pin_drive_s               narrow_pin_o,  // Narrow port drive value and enable.
	output logic      [PORT_W-1:0]   pullup_on_o    // Pull-up port pull-up enables.
);

	logic [PORT_W-1:0]   wide_data_ff;
	logic [PORT_W-1:0]   wide_dir_ff;
	logic [PORT_W-1:0]   narrow_data_ff;
	logic [PORT_W-1:0]   narrow_dir_ff;
	logic [PORT_W-1:0]   pullup_port_direction_ff;
	logic [PORT_W-1:0]   pullup_port_pullup_enable_ff;
	power_mode_e         mode_ff;
	logic [PORT_W-1:0]   wide_meta_ff;
	logic [PORT_W-1:0]   wide_sync_ff;
	logic [PORT_W-1:0]   narrow_meta_ff;
	logic [PORT_W-1:0]   narrow_sync_ff;
	logic [PORT_W-1:0]   wide_out_ff;
	logic [PORT_W-1:0]   wide_oe_ff;
	logic [PORT_W-1:0]   narrow_out_ff;
	logic [PORT_W-1:0]   narrow_oe_ff;
	logic [PORT_W-1:0]   pullup_on_ff;
	logic                ack_ff;
	logic [WB_DAT_W-1:0] rd_data_ff;
	logic [WB_DAT_W-1:0] nxt_rd_data;
	logic [PORT_W-1:0]   nxt_wide_oe;
	logic [PORT_W-1:0]   nxt_narrow_oe;
	logic [PORT_W-1:0]   nxt_pullup_on;
	logic [PORT_W-1:0]   wide_read;
	logic [PORT_W-1:0]   narrow_read;
	logic                req;
	logic                wr_lane0;
	logic [IDX_W-1:0]    idx;

	assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
	assign idx      = wb_adr_i[WB_ADR_W-1:2];

	// Two-flop synchronisers for the pin levels.
	always_ff @(posedge clk) begin
		if (reset) begin
			wide_meta_ff   <= '0;
			wide_sync_ff   <= '0;
			narrow_meta_ff <= '0;
			narrow_sync_ff <= '0;
		end else begin
			wide_meta_ff   <= wide_pin_i;
			wide_sync_ff   <= wide_meta_ff;
			narrow_meta_ff <= narrow_pin_i;
			narrow_sync_ff <= narrow_meta_ff;
		end
	end

	// Wide port data and direction registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			wide_data_ff <= WIDE_DATA_RST;
			wide_dir_ff  <= WIDE_DIR_RST;
		end else if (wr_lane0) begin
			if (idx == WIDE_DATA_IDX) begin
				wide_data_ff <= wb_dat_i[PORT_W-1:0];
			end
			if (idx == WIDE_DIR_IDX) begin
				wide_dir_ff <= wb_dat_i[PORT_W-1:0];
			end
		end
	end

	// Narrow port registers; only bits seven to three are stored.
	always_ff @(posedge clk) begin
		if (reset) begin
			narrow_data_ff <= NARROW_DATA_RST;
			narrow_dir_ff  <= NARROW_DIR_RST;
		end else if (wr_lane0) begin
			if (idx == NARROW_DATA_IDX) begin
				narrow_data_ff <= wb_dat_i[PORT_W-1:0] & NARROW_IMPL_MASK;
			end
			if (idx == NARROW_DIR_IDX) begin
				narrow_dir_ff <= wb_dat_i[PORT_W-1:0] & NARROW_IMPL_MASK;
			end
		end
	end

	// Pull-up port control registers and the power mode register.
	always_ff @(posedge clk) begin
		if (reset) begin
			pullup_port_direction_ff     <= PULLUP_DIR_RST;
			pullup_port_pullup_enable_ff <= PULLUP_EN_RST;
			mode_ff                      <= MODE_ACTIVE;
		end else if (wr_lane0) begin
			if (idx == PULLUP_DIR_IDX) begin
				pullup_port_direction_ff <= wb_dat_i[PORT_W-1:0];
			end
			if (idx == PULLUP_EN_IDX) begin
				pullup_port_pullup_enable_ff <= wb_dat_i[PORT_W-1:0];
			end
			if (idx == POWER_MODE_IDX) begin
				mode_ff <= power_mode_e'(wb_dat_i[MODE_POS +: MODE_W]);
			end
		end
	end

	// Per-bit pin enables and pull-up gating.
	for (genvar i = 0; i < PORT_W; i++) begin : g_bit
		assign nxt_wide_oe[i]   = wide_dir_ff[i];
		assign nxt_narrow_oe[i] = narrow_dir_ff[i];
		assign nxt_pullup_on[i] = ~pullup_port_direction_ff[i]
			& pullup_port_pullup_enable_ff[i];
		assign wide_read[i]     = wide_dir_ff[i] ? wide_data_ff[i]
			: wide_sync_ff[i];
		assign narrow_read[i]   = narrow_dir_ff[i] ? narrow_data_ff[i]
			: narrow_sync_ff[i];
	end

	// Pin drivers follow the power mode: frozen in sleep, released in standby.
	always_ff @(posedge clk) begin
		if (reset) begin
			wide_out_ff   <= '0;
			wide_oe_ff    <= '0;
			narrow_out_ff <= '0;
			narrow_oe_ff  <= '0;
		end else begin
			case (mode_ff)
				MODE_ACTIVE, MODE_SUBACTIVE: begin
					wide_out_ff   <= wide_data_ff;
					wide_oe_ff    <= nxt_wide_oe;
					narrow_out_ff <= narrow_data_ff;
					narrow_oe_ff  <= nxt_narrow_oe;
				end
				MODE_SLEEP: begin
					wide_out_ff   <= wide_out_ff;
					wide_oe_ff    <= wide_oe_ff;
					narrow_out_ff <= narrow_out_ff;
					narrow_oe_ff  <= narrow_oe_ff;
				end
				MODE_STANDBY: begin
					wide_out_ff   <= wide_data_ff;
					wide_oe_ff    <= '0;
					narrow_out_ff <= narrow_data_ff;
					narrow_oe_ff  <= '0;
				end
				default: begin
					wide_out_ff   <= '0;
					wide_oe_ff    <= '0;
					narrow_out_ff <= '0;
					narrow_oe_ff  <= '0;
				end
			endcase
		end
	end

	// Pull-ups stay as configured in standby so a pulled pin sits high, and hold in sleep.
	always_ff @(posedge clk) begin
		if (reset) begin
			pullup_on_ff <= PULLUP_ON_RST;
		end else if (mode_ff != MODE_SLEEP) begin
			pullup_on_ff <= nxt_pullup_on;
		end
	end

	// Read data mux; unmapped addresses answer with zero.
	always_comb begin
		nxt_rd_data = UNMAPPED_READ;
		case (idx)
			WIDE_DATA_IDX:   nxt_rd_data[PORT_W-1:0] = wide_read;
			NARROW_DATA_IDX: nxt_rd_data[PORT_W-1:0] = narrow_read & NARROW_IMPL_MASK;
			WIDE_DIR_IDX:    nxt_rd_data[PORT_W-1:0] = WRITE_ONLY_READ;
			NARROW_DIR_IDX:  nxt_rd_data[PORT_W-1:0] = WRITE_ONLY_READ;
			PULLUP_DIR_IDX:  nxt_rd_data[PORT_W-1:0] = WRITE_ONLY_READ;
			PULLUP_EN_IDX:   nxt_rd_data[PORT_W-1:0] = pullup_port_pullup_enable_ff;
			POWER_MODE_IDX:  nxt_rd_data[MODE_POS +: MODE_W] = mode_ff;
			default:         nxt_rd_data = UNMAPPED_READ;
		endcase
	end

	// Bus answer: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk) begin
		if (reset) begin
			ack_ff     <= 1'b0;
			rd_data_ff <= '0;
		end else begin
			ack_ff <= req;
			if (req && !wb_we_i) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	assign wb_ack_o          = ack_ff;
	assign wb_dat_o          = rd_data_ff;
	assign wide_pin_o        = '{dout: wide_out_ff, oe: wide_oe_ff};
	assign narrow_pin_o      = '{dout: narrow_out_ff, oe: narrow_oe_ff};
	assign pullup_on_o       = pullup_on_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence rd_at(logic [IDX_W-1:0] where);
		req && !wb_we_i && idx == where;
	endsequence

	sequence wr_at(logic [IDX_W-1:0] where);
		wr_lane0 && idx == where;
	endsequence

	chk_pullup_gate_on: assert property (
		nxt_pullup_on != pullup_on_ff && mode_ff != MODE_SLEEP
		|=> pullup_on_ff == $past(~pullup_port_direction_ff & pullup_port_pullup_enable_ff))
		else $error("pull-up does not follow direction and enable");

	chk_pullup_output_off: assert property (
		mode_ff != MODE_SLEEP |=> (pullup_on_ff & $past(pullup_port_direction_ff)) == 8'h00)
		else $error("pull-up on for an output pin");

	chk_pullup_reset_off: assert property (
		$fell(reset) |-> pullup_on_ff == PULLUP_ON_RST)
		else $error("pull-up on after reset");

	chk_wide_reset_clear: assert property (
		$fell(reset) |-> wide_data_ff == WIDE_DATA_RST && wide_dir_ff == WIDE_DIR_RST
		&& wide_oe_ff == 8'h00)
		else $error("wide port not cleared by reset");

	chk_wide_read_mix: assert property (
		rd_at(WIDE_DATA_IDX) |=> wb_ack_o
		&& wb_dat_o[7:0] == $past((wide_data_ff & wide_dir_ff) | (wide_sync_ff & ~wide_dir_ff)))
		else $error("wide port read value wrong");

	chk_dir_read_ones: assert property (
		rd_at(WIDE_DIR_IDX) or rd_at(NARROW_DIR_IDX) |=> wb_ack_o && wb_dat_o[7:0] == 8'hff)
		else $error("direction register does not read all ones");

	chk_narrow_read_mix: assert property (
		rd_at(NARROW_DATA_IDX) |=> wb_dat_o[2:0] == 3'b000
		&& wb_dat_o[7:3] == $past(narrow_dir_ff[7:3] & narrow_data_ff[7:3]
		| ~narrow_dir_ff[7:3] & narrow_sync_ff[7:3]))
		else $error("narrow port read value wrong");

	chk_active_drive: assert property (
		mode_ff == MODE_ACTIVE |=> wide_oe_ff == $past(wide_dir_ff)
		&& wide_out_ff == $past(wide_data_ff) && narrow_oe_ff == $past(narrow_dir_ff)
		&& narrow_out_ff[2:0] == 3'b000)
		else $error("pin drive does not follow registers");

	chk_sleep_hold: assert property (
		mode_ff == MODE_SLEEP |=> $stable(wide_out_ff) && $stable(wide_oe_ff)
		&& $stable(narrow_oe_ff) && $stable(pullup_on_ff))
		else $error("pins changed in sleep");

	chk_standby_release: assert property (
		mode_ff == MODE_STANDBY |=> wide_oe_ff == 8'h00 && narrow_oe_ff == 8'h00
		&& pullup_on_ff == $past(nxt_pullup_on))
		else $error("standby pin state wrong");

	chk_narrow_reset_clear: assert property (
		$fell(reset) |-> narrow_data_ff == 8'h00 && narrow_dir_ff == 8'h00
		&& narrow_oe_ff == 8'h00)
		else $error("narrow port not cleared by reset");

	chk_ack_one_cycle: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	chk_ack_after_req: assert property (
		req |=> wb_ack_o)
		else $error("request not answered in one cycle");

	chk_write_keeps_data: assert property (
		req && wb_we_i |=> $stable(wb_dat_o))
		else $error("write changed the read data");

	chk_wide_data_write: assert property (
		wr_at(WIDE_DATA_IDX) |=> wide_data_ff == $past(wb_dat_i[7:0]))
		else $error("wide data write lost");

	chk_wide_dir_write: assert property (
		wr_at(WIDE_DIR_IDX) |=> wide_dir_ff == $past(wb_dat_i[7:0]))
		else $error("wide direction write lost");

	chk_narrow_data_write: assert property (
		wr_at(NARROW_DATA_IDX) |=> narrow_data_ff == {$past(wb_dat_i[7:3]), 3'b000})
		else $error("narrow data write not masked");

	chk_narrow_dir_write: assert property (
		wr_at(NARROW_DIR_IDX) |=> narrow_dir_ff == {$past(wb_dat_i[7:3]), 3'b000})
		else $error("narrow direction write not masked");

	chk_narrow_reserved: assert property (
		narrow_data_ff[2:0] == 3'b000 && narrow_out_ff[2:0] == 3'b000
		&& narrow_oe_ff[2:0] == 3'b000)
		else $error("narrow reserved bits not zero");

	chk_subactive_drive: assert property (
		mode_ff == MODE_SUBACTIVE |=> wide_oe_ff == $past(wide_dir_ff)
		&& wide_out_ff == $past(wide_data_ff) && narrow_out_ff == $past(narrow_data_ff))
		else $error("pins not functional in subactive");

	chk_pin_sync_delay: assert property (
		!$past(reset) && !$past(reset, 2) |-> wide_sync_ff == $past(wide_pin_i, 2)
		&& narrow_sync_ff == $past(narrow_pin_i, 2))
		else $error("pin synchroniser delay wrong");

	chk_mode_readback: assert property (
		rd_at(POWER_MODE_IDX) |=> wb_dat_o[MODE_POS +: MODE_W] == $past(mode_ff))
		else $error("power mode read value wrong");

	chk_enable_readback: assert property (
		rd_at(PULLUP_EN_IDX) |=> wb_dat_o[7:0] == $past(pullup_port_pullup_enable_ff))
		else $error("pull-up enable read value wrong");

endmodule // gpio_ports
